// ### mon_if.sv
// carrier between the register side and one reference monitor
// assumes both ends share the system clock
`timescale 1ns/1ps
interface mon_if;
	logic        tick;
	logic        ref_edge;
	logic [2:0]  freq;
	logic        lim_sel;
	logic [15:0] sp_upper;
	logic [15:0] sp_lower;
	logic        sp_fail;
	logic        mp_fail;
	modport ctrl (output tick, ref_edge, freq, lim_sel, sp_upper, sp_lower,
		input sp_fail, mp_fail);
	modport mon (input tick, ref_edge, freq, lim_sel, sp_upper, sp_lower,
		output sp_fail, mp_fail);
endinterface : mon_if

// ### pll_reference_monitor_phase_control.sv
// reference monitors, register file and output phase control of the loop
// assumes synchronous reference inputs and a phase error word from the loop filter
`timescale 1ns/1ps
module pll_reference_monitor_phase_control import refmon_pkg::*; #(
	parameter int TIME_BASE_DIV = 1
) (
	input  wire logic               i_sys_clk,
	input  wire logic               i_reset_n,
	input  wire logic [ADDR_W-1:0]  i_addr,
	input  wire logic [DATA_W-1:0]  i_wdata,
	input  wire logic               i_wr,
	input  wire logic               i_rd,
	output logic      [DATA_W-1:0]  o_rdata,
	input  wire logic [NUM_REF-1:0] i_reference_clock_inputs,
	input  wire logic               i_ref_switch,
	input  wire logic signed [15:0] i_phase_err,
	output logic signed [15:0]      o_phase,
	output logic                    o_phase_step,
	output logic      [2:0]         o_ref_select,
	output logic      [NUM_REF-1:0] o_ref_valid
);
	logic [2:0]  ref_chg_q, ref_chg_d;
	logic        lsel_q, lsel_d;
	logic [7:0]  slew_q, slew_d;
	logic [7:0]  mask_q, mask_d;
	logic [11:0] freq_q, freq_d;
	logic [15:0] sp_up_q [NUM_REF];
	logic [15:0] sp_up_d [NUM_REF];
	logic [15:0] sp_lo_q [NUM_REF];
	logic [15:0] sp_lo_d [NUM_REF];
	logic [15:0] rdata_q, rdata_d;
	logic        tick_q, tick_d;
	logic [NUM_REF-1:0] ref_q, ref_edge, sp_fail, mp_fail;
	logic [NUM_REF-1:0] valid_q, valid_d;
	ph_state_t   state_q, state_d;
	logic signed [15:0] buildout_q, buildout_d, out_q, out_d, target, diff;
	logic [19:0] acc_q, acc_d;
	logic [20:0] acc_sum;
	logic        step_q, step_d;
	logic        wr_ref_chg, realign, rearr, lim_hit;
	logic [2:0]  lim_idx;

	mon_if mif [NUM_REF] ();

	// one monitor per reference
	generate
		for (genvar g = 0; g < NUM_REF; g++) begin : g_mon
			assign ref_edge[g]     = i_reference_clock_inputs[g] & ~ref_q[g];
			assign mif[g].tick     = tick_q;
			assign mif[g].ref_edge = ref_edge[g];
			assign mif[g].freq     = freq_q[3*g +: 3];
			assign mif[g].lim_sel  = lsel_q; // [R16]
			assign mif[g].sp_upper = sp_up_q[g]; // [R9]
			assign mif[g].sp_lower = sp_lo_q[g]; // [R9]
			assign sp_fail[g]      = mif[g].sp_fail;
			assign mp_fail[g]      = mif[g].mp_fail;
			ref_monitor #(
				.TIME_BASE_DIV (TIME_BASE_DIV)
			) u_mon (
				.i_sys_clk (i_sys_clk),
				.i_reset_n (i_reset_n),
				.mif       (mif[g])
			); // [R6]
		end
	endgenerate

	// register writes
	always_comb begin
		wr_ref_chg = i_wr && (i_addr == REF_CHG_ADDR);
		realign    = wr_ref_chg && i_wdata[REALIGN_BIT]; // [R2]
		rearr      = (wr_ref_chg && (i_wdata[2:0] != ref_chg_q)) || i_ref_switch; // [R1]
		lim_idx    = 3'(i_addr - SPLIM_BASE);
		lim_hit    = (i_addr >= SPLIM_BASE) && (i_addr < SPLIM_BASE + 5'(2 * NUM_REF));
		ref_chg_d  = wr_ref_chg ? i_wdata[2:0] : ref_chg_q;
		lsel_d  = lsel_q;
		slew_d  = slew_q;
		mask_d  = mask_q;
		freq_d  = freq_q;
		if (i_wr && i_addr == LOOP_CTRL_ADDR) begin
			lsel_d = i_wdata[LIMIT_SEL_BIT]; // [R16]
		end
		if (i_wr && i_addr == SLEW_ADDR) begin
			slew_d = (i_wdata[7:0] > SLEW_MAX) ? SLEW_MAX : i_wdata[7:0]; // [R4]
		end
		if (i_wr && i_addr == MASK_ADDR) begin
			mask_d = i_wdata[7:0]; // [R8]
		end
		if (i_wr && i_addr == FREQ_ADDR) begin
			freq_d = i_wdata[11:0]; // [R19]
		end
		for (int i = 0; i < NUM_REF; i++) begin
			sp_up_d[i] = sp_up_q[i];
			sp_lo_d[i] = sp_lo_q[i];
		end
		if (i_wr && lim_hit) begin
			if (lim_idx[0]) begin
				sp_lo_d[lim_idx[2:1]] = i_wdata; // [R9] [R11]
			end else begin
				sp_up_d[lim_idx[2:1]] = i_wdata; // [R9] [R11]
			end
		end
		// validity: a masked result is ignored
		valid_d = ~((sp_fail & ~mask_q[3:0]) | (mp_fail & ~mask_q[7:4])); // [R8]
	end

	// register reads, data one cycle later
	always_comb begin
		rdata_d = 16'h0000;
		if (i_rd) begin
			if (i_addr == REF_CHG_ADDR) begin
				rdata_d = {13'h0000, ref_chg_q};
			end else if (i_addr == LOOP_CTRL_ADDR) begin
				rdata_d = {15'h0000, lsel_q};
			end else if (i_addr == SLEW_ADDR) begin
				rdata_d = {8'h00, slew_q};
			end else if (i_addr == STATUS_ADDR) begin
				rdata_d = {4'h0, valid_q, mp_fail, sp_fail}; // [R8]
			end else if (i_addr == MASK_ADDR) begin
				rdata_d = {8'h00, mask_q};
			end else if (i_addr == FREQ_ADDR) begin
				rdata_d = {4'h0, freq_q};
			end else if (i_addr == PHASE_ADDR) begin
				rdata_d = out_q;
			end else if (lim_hit) begin
				rdata_d = lim_idx[0] ? sp_lo_q[lim_idx[2:1]] : sp_up_q[lim_idx[2:1]];
			end
		end
	end

	// slew limiter: one phase unit per million ticks times the slew in ppm
	always_comb begin
		tick_d  = ~tick_q;
		acc_sum = {1'b0, acc_q} + {13'h0000, slew_q};
		acc_d   = acc_q;
		step_d  = 1'b0;
		if (tick_q) begin
			if (acc_sum >= PPM_SCALE) begin
				acc_d  = 20'(acc_sum - PPM_SCALE); // [R4]
				step_d = 1'b1;
			end else begin
				acc_d = acc_sum[19:0];
			end
		end
	end

	// output phase: hold over rearrangements, realign on request
	always_comb begin
		target     = i_phase_err - buildout_q;
		diff       = target - out_q;
		buildout_d = buildout_q;
		out_d      = out_q;
		unique case (state_q)
			PH_TRACK: begin
				if (step_q && diff > 16'sh0000) begin
					out_d = out_q + 16'sh0001; // [R4]
				end else if (step_q && diff < 16'sh0000) begin
					out_d = out_q - 16'sh0001; // [R4]
				end
			end
			PH_HOLD: begin
				buildout_d = i_phase_err - out_q; // [R1]
			end
			PH_ALIGN: begin
				buildout_d = 16'sh0000; // [R2]
				out_d      = i_phase_err; // [R2]
			end
			default: begin
				buildout_d = buildout_q;
			end
		endcase
		if (realign) begin
			state_d = PH_ALIGN;
		end else if (rearr) begin
			state_d = PH_HOLD;
		end else begin
			state_d = PH_TRACK;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ref_chg_q  <= REF_CHG_RST;
			lsel_q     <= 1'b0;
			slew_q     <= SLEW_RST;
			mask_q     <= MASK_RST;
			freq_q     <= FREQ_RST;
			for (int i = 0; i < NUM_REF; i++) begin
				sp_up_q[i] <= SP_UPPER_RST;
				sp_lo_q[i] <= SP_LOWER_RST;
			end
			rdata_q    <= 16'h0000;
			tick_q     <= 1'b0;
			ref_q      <= '0;
			valid_q    <= '0;
			state_q    <= PH_TRACK;
			buildout_q <= 16'sh0000;
			out_q      <= 16'sh0000;
			acc_q      <= 20'h00000;
			step_q     <= 1'b0;
		end else begin
			ref_chg_q  <= ref_chg_d;
			lsel_q     <= lsel_d;
			slew_q     <= slew_d;
			mask_q     <= mask_d;
			freq_q     <= freq_d;
			for (int i = 0; i < NUM_REF; i++) begin
				sp_up_q[i] <= sp_up_d[i];
				sp_lo_q[i] <= sp_lo_d[i];
			end
			rdata_q    <= rdata_d;
			tick_q     <= tick_d;
			ref_q      <= i_reference_clock_inputs;
			valid_q    <= valid_d;
			state_q    <= state_d;
			buildout_q <= buildout_d;
			out_q      <= out_d;
			acc_q      <= acc_d;
			step_q     <= step_d;
		end
	end

	assign o_rdata      = rdata_q;
	assign o_phase      = out_q;
	assign o_phase_step = step_q;
	assign o_ref_select = ref_chg_q;
	assign o_ref_valid  = valid_q;

	sequence s_realign_req;
		i_wr && (i_addr == REF_CHG_ADDR) && i_wdata[REALIGN_BIT];
	endsequence
	sequence s_rearr_req;
		rearr && !realign;
	endsequence

	a_realign_snap: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // [R2]
		s_realign_req |=> (state_q == PH_ALIGN) ##1 (o_phase == $past(i_phase_err)))
		else $error("realign did not snap output phase");
	a_hold_bound: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // [R1]
		s_rearr_req |=> (state_q == PH_HOLD) ##1
		((o_phase - $past(o_phase) <= 16'(PH_BOUND_UNITS))
		&& ($past(o_phase) - o_phase <= 16'(PH_BOUND_UNITS))))
		else $error("rearrangement moved output phase too far");
	a_slew_clamp: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // [R4]
		(i_wr && i_addr == SLEW_ADDR && i_wdata[7:0] > SLEW_MAX) |=> (slew_q == SLEW_MAX))
		else $error("slew limit not clamped");
	a_slew_residue: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // [R4]
		step_q |-> (acc_q < {12'h000, slew_q}))
		else $error("phase step faster than slew limit");
	a_status_read: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // [R8]
		(i_rd && i_addr == STATUS_ADDR) |=> (o_rdata[7:0] == $past({mp_fail, sp_fail})))
		else $error("status read does not show monitor results");
	a_mask_ignore: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // [R8]
		(mask_q == 8'hff) |=> (o_ref_valid == 4'hf))
		else $error("masked references not valid");
endmodule : pll_reference_monitor_phase_control

// ### pll_reference_monitor_phase_control_test.sv
// self-checking bench for the reference monitor and phase control
// assumes four ref_source models on the reference inputs
`timescale 1ns/1ps
module pll_reference_monitor_phase_control_test import refmon_pkg::*;;
	logic               i_sys_clk    = 1'b0;
	logic               i_reset_n    = 1'b0;
	logic [ADDR_W-1:0]  i_addr       = '0;
	logic [DATA_W-1:0]  i_wdata      = '0;
	logic               i_wr         = 1'b0;
	logic               i_rd         = 1'b0;
	logic               i_ref_switch = 1'b0;
	logic signed [15:0] i_phase_err  = '0;
	logic [NUM_REF-1:0] run          = '0;
	logic [NUM_REF-1:0] refs;
	logic [DATA_W-1:0]  o_rdata;
	logic signed [15:0] o_phase;
	logic               o_phase_step;
	logic [2:0]         o_ref_select;
	logic [NUM_REF-1:0] o_ref_valid;
	logic [15:0]        period [NUM_REF];
	int                 failures = 0;
	int                 n_checks = 0;
	int                 cyc      = 0;

	always #2.5 i_sys_clk = ~i_sys_clk;

	for (genvar g = 0; g < NUM_REF; g++) begin : g_src
		ref_source i_src (.i_sys_clk(i_sys_clk), .i_run(run[g]), .i_period(period[g]),
			.o_ref(refs[g]));
	end

	pll_reference_monitor_phase_control #(.TIME_BASE_DIV(1000000)) i_dut (
		.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_reference_clock_inputs(refs), .i_ref_switch(i_ref_switch),
		.i_phase_err(i_phase_err), .o_phase(o_phase), .o_phase_step(o_phase_step),
		.o_ref_select(o_ref_select), .o_ref_valid(o_ref_valid));

	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : close_out

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge i_sys_clk);
		i_wr    <= 1'b1;
		i_addr  <= a;
		i_wdata <= d;
		@(posedge i_sys_clk);
		i_wr <= 1'b0;
	endtask : wr

	task automatic rchk(input logic [4:0] a, input logic [15:0] e);
		@(posedge i_sys_clk);
		i_rd   <= 1'b1;
		i_addr <= a;
		@(posedge i_sys_clk);
		i_rd <= 1'b0;
		#1;
		check($sformatf("reg %h", a), o_rdata, e);
	endtask : rchk

	task automatic settle(input int n);
		repeat (n) @(posedge i_sys_clk);
		#1;
	endtask : settle

	task automatic t_reset_values();
		check("valid", 16'(o_ref_valid), 16'h0000);
		rchk(REF_CHG_ADDR, 16'h0000);
		rchk(LOOP_CTRL_ADDR, 16'h0000);
		rchk(SLEW_ADDR, 16'h0038);
		rchk(STATUS_ADDR, 16'h00ff);
		rchk(MASK_ADDR, 16'h0000);
		rchk(FREQ_ADDR, 16'h0000);
		rchk(PHASE_ADDR, 16'h0000);
		rchk(5'h07, 16'h0000);
		rchk(5'h10, 16'h0000);
		for (int n = 0; n < NUM_REF; n++) begin
			rchk(SPLIM_BASE + 5'(2 * n), 16'hffff);
			rchk(SPLIM_BASE + 5'(2 * n + 1), 16'h0000);
		end
	endtask : t_reset_values

	task automatic t_registers();
		wr(SLEW_ADDR, 16'h003d);
		rchk(SLEW_ADDR, 16'h003d);
		wr(SLEW_ADDR, 16'h00ff);
		rchk(SLEW_ADDR, 16'h00ba);
		wr(LOOP_CTRL_ADDR, 16'h0001);
		rchk(LOOP_CTRL_ADDR, 16'h0001);
		wr(LOOP_CTRL_ADDR, 16'h0000);
		wr(FREQ_ADDR, 16'h0fac);
		rchk(FREQ_ADDR, 16'h0fac);
		wr(STATUS_ADDR, 16'h0000);
		rchk(STATUS_ADDR, 16'h00ff);
		wr(PHASE_ADDR, 16'h1234);
		rchk(PHASE_ADDR, 16'h0000);
		wr(5'h10, 16'hffff);
		rchk(5'h10, 16'h0000);
		wr(REF_CHG_ADDR, 16'h0005);
		rchk(REF_CHG_ADDR, 16'h0005);
		check("select", 16'(o_ref_select), 16'h0005);
	endtask : t_registers

	task automatic t_single_period();
		// 40 cycles = 20 ticks, inside 16..24
		for (int n = 0; n < NUM_REF; n++) begin
			wr(SPLIM_BASE + 5'(2 * n), 16'd24);
			wr(SPLIM_BASE + 5'(2 * n + 1), 16'd16);
		end
		wr(MASK_ADDR, 16'h00f0);
		run <= 4'hf;
		settle(400);
		rchk(STATUS_ADDR, 16'h0ff0);
		check("valid all", 16'(o_ref_valid), 16'h000f);
		period[1] <= 16'd60;
		period[2] <= 16'd24;
		run[3]    <= 1'b0;
		settle(400);
		rchk(STATUS_ADDR, 16'h01fe);
		check("valid bad", 16'(o_ref_valid), 16'h0001);
		wr(MASK_ADDR, 16'h00ff);
		settle(3);
		check("valid masked", 16'(o_ref_valid), 16'h000f);
		rchk(STATUS_ADDR, 16'h0ffe);
		wr(MASK_ADDR, 16'h00f0);
		period[1] <= 16'd40;
		period[2] <= 16'd40;
		run       <= 4'hf;
		settle(400);
		check("valid again", 16'(o_ref_valid), 16'h000f);
	endtask : t_single_period

	task automatic t_multi_period();
		// ref0 at code 2: 20 periods of 100 cycles give exactly 1000 ticks
		wr(FREQ_ADDR, 16'h0002);
		wr(MASK_ADDR, 16'h000f);
		period[0] <= 16'd100;
		settle(7000);
		rchk(STATUS_ADDR, 16'h01e1);
		check("valid near", 16'(o_ref_valid), 16'h0001);
		period[0] <= 16'd102;
		settle(7000);
		rchk(STATUS_ADDR, 16'h00f1);
		check("valid far", 16'(o_ref_valid), 16'h0000);
	endtask : t_multi_period

	task automatic t_phase();
		int bad;
		bad = 0;
		@(posedge i_sys_clk);
		i_phase_err <= 16'sh0123;
		wr(REF_CHG_ADDR, 16'h0085);
		settle(3);
		check("phase align", o_phase, 16'h0123);
		rchk(REF_CHG_ADDR, 16'h0005);
		rchk(PHASE_ADDR, 16'h0123);
		@(posedge i_sys_clk);
		i_phase_err  <= 16'sh0200;
		i_ref_switch <= 1'b1;
		@(posedge i_sys_clk);
		i_ref_switch <= 1'b0;
		for (int c = 0; c < 600; c++) begin
			if (c == 300)
				wr(REF_CHG_ADDR, 16'h0003);
			if (c == 300)
				i_phase_err <= 16'sh0050;
			settle(1);
			if (int'(o_phase) > 294 || int'(o_phase) < 288)
				bad++;
		end
		check("phase moves", 16'(bad), 16'h0000);
		wr(REF_CHG_ADDR, 16'h0083);
		settle(3);
		check("phase realign", o_phase, 16'h0050);
	endtask : t_phase

	task automatic wait_step(output int n);
		n = 0;
		do begin
			settle(1);
			n++;
		end while (o_phase_step !== 1'b1 && n < 12000);
	endtask : wait_step

	task automatic t_slew();
		int n;
		// slew stays clamped at 186 ppm
		wait_step(n);
		for (int k = 0; k < 2; k++) begin
			wait_step(n);
			check("step gap", 16'(n >= 10750 && n <= 10756), 16'h0001);
		end
	endtask : t_slew

	always @(posedge i_sys_clk) begin
		cyc++;
		if (cyc == 80000) begin
			failures++;
			close_out();
		end
	end

	initial begin
		for (int n = 0; n < NUM_REF; n++)
			period[n] = 16'd40;
		repeat (6) @(posedge i_sys_clk);
		i_reset_n <= 1'b1;
		settle(1);
		t_reset_values();
		t_registers();
		t_single_period();
		t_multi_period();
		t_phase();
		t_slew();
		close_out();
	end
endmodule : pll_reference_monitor_phase_control_test

// ### ref_monitor.sv
// single-period and multi-period quality monitor for one reference
// assumes edges and ticks are one-cycle pulses on the system clock
`timescale 1ns/1ps
module ref_monitor import refmon_pkg::*; #(
	parameter int TIME_BASE_DIV = 1
) (
	input  wire logic i_sys_clk,
	input  wire logic i_reset_n,
	mon_if.mon        mif
);
	localparam logic [29:0] EXP_S = 30'(EXP_TICKS / TIME_BASE_DIV);

	logic [15:0] per_q, per_d;
	logic        armed_q, armed_d, sp_fail_q, sp_fail_d;
	logic [27:0] cyc_q, cyc_d, target;
	logic [29:0] ticks_q, ticks_d, dev, far_lim, near_lim;
	logic        run_q, run_d, prev_far_q, prev_far_d, prev_near_q, prev_near_d;
	logic        mp_fail_q, mp_fail_d, win_end, far_now, near_now;

	always_comb begin
		unique case (mif.freq) // [R19]
			3'h1:    target = 28'(CYC_1M544 / TIME_BASE_DIV);
			3'h2:    target = 28'(CYC_2M048 / TIME_BASE_DIV);
			3'h3:    target = 28'(CYC_4M096 / TIME_BASE_DIV);
			3'h4:    target = 28'(CYC_8M192 / TIME_BASE_DIV);
			3'h5:    target = 28'(CYC_16M384 / TIME_BASE_DIV);
			3'h6:    target = 28'(CYC_19M44 / TIME_BASE_DIV);
			default: target = 28'(CYC_8K / TIME_BASE_DIV);
		endcase
		far_lim  = mif.lim_sel ? 30'(FAR_REL_TICKS / TIME_BASE_DIV) // [R16] [R18]
			: 30'(FAR_DEF_TICKS / TIME_BASE_DIV); // [R17]
		near_lim = mif.lim_sel ? 30'(NEAR_REL_TICKS / TIME_BASE_DIV)
			: 30'(NEAR_DEF_TICKS / TIME_BASE_DIV);
		// single period: ticks between edges against the limits
		per_d     = per_q;
		armed_d   = armed_q | mif.ref_edge;
		sp_fail_d = sp_fail_q;
		if (mif.ref_edge) begin
			per_d = 16'h0000;
			if (armed_q) begin
				sp_fail_d = (per_q > mif.sp_upper) || (per_q < mif.sp_lower); // [R9] [R20]
			end
		end else begin
			if (mif.tick && per_q != 16'hffff) begin
				per_d = per_q + 16'h0001;
			end
			if (armed_q && per_q > mif.sp_upper) begin
				sp_fail_d = 1'b1; // [R10]
			end
		end
		// multi period: ticks over the time base in reference cycles
		win_end  = mif.ref_edge && run_q && (cyc_q >= target - 28'h1); // [R14]
		dev      = (ticks_q >= EXP_S) ? ticks_q - EXP_S : EXP_S - ticks_q;
		far_now  = dev > far_lim;
		near_now = dev <= near_lim;
		run_d    = run_q | mif.ref_edge;
		cyc_d    = cyc_q;
		ticks_d  = ticks_q;
		if (mif.tick && ticks_q != 30'h3fff_ffff) begin
			ticks_d = ticks_q + 30'h1;
		end
		// the tick of the edge cycle opens the new window
		if (mif.ref_edge && !run_q) begin
			cyc_d   = 28'h0;
			ticks_d = 30'(mif.tick);
		end else if (win_end) begin
			cyc_d   = 28'h0;
			ticks_d = 30'(mif.tick);
		end else if (mif.ref_edge) begin
			cyc_d = cyc_q + 28'h1;
		end
		prev_far_d  = prev_far_q;
		prev_near_d = prev_near_q;
		mp_fail_d   = mp_fail_q;
		if (win_end) begin
			prev_far_d  = far_now;
			prev_near_d = near_now;
			if (far_now && prev_far_q) begin
				mp_fail_d = 1'b1; // [R12] [R13]
			end else if (near_now && prev_near_q) begin
				mp_fail_d = 1'b0; // [R12] [R13] [R15]
			end
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			per_q       <= 16'h0000;
			armed_q     <= 1'b0;
			sp_fail_q   <= 1'b1;
			cyc_q       <= 28'h0;
			ticks_q     <= 30'h0;
			run_q       <= 1'b0;
			prev_far_q  <= 1'b0;
			prev_near_q <= 1'b0;
			mp_fail_q   <= 1'b1;
		end else begin
			per_q       <= per_d;
			armed_q     <= armed_d;
			sp_fail_q   <= sp_fail_d;
			cyc_q       <= cyc_d;
			ticks_q     <= ticks_d;
			run_q       <= run_d;
			prev_far_q  <= prev_far_d;
			prev_near_q <= prev_near_d;
			mp_fail_q   <= mp_fail_d;
		end
	end

	assign mif.sp_fail = sp_fail_q; // [R7]
	assign mif.mp_fail = mp_fail_q; // [R7]

	a_sp_late_loss: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // [R10]
		(armed_q && !mif.ref_edge && per_q > mif.sp_upper) |=> sp_fail_q)
		else $error("late reference edge not flagged");
	a_mp_fail_two: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // [R13]
		$rose(mp_fail_q) |-> $past(win_end && far_now && prev_far_q))
		else $error("frequency fail without two far measurements");
	a_mp_pass_near: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // [R12]
		$fell(mp_fail_q) |-> $past(win_end && near_now && prev_near_q))
		else $error("frequency pass without two near measurements");
endmodule : ref_monitor

// ### ref_source.sv
// behavioural model of one external reference clock source
// assumes a period given in system clock cycles, output synchronous to that clock
`timescale 1ns/1ps
module ref_source (
	input  wire logic        i_sys_clk,
	input  wire logic        i_run,
	input  wire logic [15:0] i_period,
	output logic             o_ref
);
	logic [15:0] cnt_q;
	initial begin
		cnt_q = '0;
		o_ref = 1'b0;
	end
	// stopped source stands low, no stray edges
	always @(posedge i_sys_clk) begin
		if (!i_run) begin
			cnt_q <= '0;
			o_ref <= 1'b0;
		end else begin
			cnt_q <= (cnt_q + 16'h1 >= i_period) ? 16'h0 : cnt_q + 16'h1;
			o_ref <= (cnt_q < (i_period >> 1));
		end
	end
endmodule : ref_source

// ### refmon_pkg.sv
// constants, register map and state types of the reference monitor and phase control
// assumes one 200 MHz system clock and a monitor tick of 100 MHz made from it
// Functional notes
// [R1] a reference or mode rearrangement moves output phase less than 31 ns
// [R2] setting the realign bit snaps output phase to the selected reference edge
// [R3] software should realign after many switches since residual errors accumulate
// [R4] phase alignment speed is limited by a slew value, max 186, reset 56 ppm
// [R5] software should keep the slew within 81 ns per 1.326 ms, about 61 ppm
// [R6] four independent monitors, one per reference input, run continuously
// [R7] each monitor checks single-period deviation and multi-period frequency with hysteresis
// [R8] monitor results readable in a status register, ignorable through a mask register
// [R9] single-period upper and lower limits are programmable counts of 10 ns
// [R10] single-period limits are looser, giving early loss or big phase jump detection
// [R11] single-period tolerance is 10 UI at 8 kHz, 0.3 or 0.2 UI above
// [R12] multi-period fails beyond far limits and passes again only inside near limits
// [R13] multi-period verdict needs two consecutive measurements
// [R14] multi-period time base is 10 s, counted in monitored reference cycles
// [R15] reference validation completes within 10 to 30 seconds
// [R16] limit set select bit in loop control picks default or relaxed limits
// [R17] default limits: far 82.487 ppm, near 64.713 ppm either side
// [R18] relaxed limits: far 250 ppm, near 240 ppm either side
// [R19] monitors handle 8 kHz, 1.544, 2.048, 4.096, 8.192, 16.384, 19.44 MHz
// [R20] periods are counted in 100 MHz ticks and compared against limit registers
package refmon_pkg;
	localparam int          ADDR_W          = 5;
	localparam int          DATA_W          = 16;
	localparam int          NUM_REF         = 4;
	// register offsets
	localparam logic [4:0]  REF_CHG_ADDR    = 5'h00;
	localparam logic [4:0]  LOOP_CTRL_ADDR  = 5'h01;
	localparam logic [4:0]  SLEW_ADDR       = 5'h02;
	localparam logic [4:0]  STATUS_ADDR     = 5'h03;
	localparam logic [4:0]  MASK_ADDR       = 5'h04;
	localparam logic [4:0]  FREQ_ADDR       = 5'h05;
	localparam logic [4:0]  PHASE_ADDR      = 5'h06;
	localparam logic [4:0]  SPLIM_BASE      = 5'h08;
	// field positions
	localparam int          REALIGN_BIT     = 7;
	localparam int          LIMIT_SEL_BIT   = 0;
	// reset values and slew maximum
	localparam logic [2:0]  REF_CHG_RST     = 3'h0;
	localparam logic [7:0]  SLEW_RST        = 8'h38;
	localparam logic [7:0]  SLEW_MAX        = 8'hba;
	localparam logic [7:0]  MASK_RST        = 8'h00;
	localparam logic [11:0] FREQ_RST        = 12'h000;
	localparam logic [15:0] SP_UPPER_RST    = 16'hffff;
	localparam logic [15:0] SP_LOWER_RST    = 16'h0000;
	// timing
	localparam int          SYS_CLK_MHZ     = 200;
	localparam int          MON_CLK_MHZ     = 100;
	localparam int          TICK_DIV        = SYS_CLK_MHZ / MON_CLK_MHZ;
	localparam int          PHASE_UNIT_NS   = 1000 / MON_CLK_MHZ;
	localparam int          PH_BOUND_NS     = 31;
	localparam int          PH_BOUND_UNITS  = PH_BOUND_NS / PHASE_UNIT_NS;
	localparam logic [20:0] PPM_SCALE       = 21'h0f4240;
	localparam int          TB_SECONDS      = 10;
	localparam logic [29:0] EXP_TICKS       = 30'(TB_SECONDS * MON_CLK_MHZ * 1000000);
	// hysteresis limits as tick deviation over the time base
	localparam logic [29:0] FAR_DEF_TICKS   = 30'h0001_4237;
	localparam logic [29:0] NEAR_DEF_TICKS  = 30'h0000_fcc9;
	localparam logic [29:0] FAR_REL_TICKS   = 30'h0003_d090;
	localparam logic [29:0] NEAR_REL_TICKS  = 30'h0003_a980;
	// reference cycles per time base, by frequency code
	localparam logic [27:0] CYC_8K          = 28'h001_3880;
	localparam logic [27:0] CYC_1M544       = 28'h0eb_9880;
	localparam logic [27:0] CYC_2M048       = 28'h138_8000;
	localparam logic [27:0] CYC_4M096       = 28'h271_0000;
	localparam logic [27:0] CYC_8M192       = 28'h4e2_0000;
	localparam logic [27:0] CYC_16M384      = 28'h9c4_0000;
	localparam logic [27:0] CYC_19M44       = 28'hb96_4f00;
	typedef enum logic [1:0] {
		PH_TRACK = 2'b00,
		PH_HOLD  = 2'b01,
		PH_ALIGN = 2'b11
	} ph_state_t;
endpackage : refmon_pkg
